// ---- hdl/uncore_cache_event_selector.sv ----
// Overview of operation
// - Event 08h mask 02h counts writeback hits; all writebacks hit.
// - Event 08h mask 04h counts io_hub or remote snoop hits.
// - Event 08h mask 03h counts all read and write hits.
// - Event 09h mask 01h counts code, data read and RFO misses.
// - Event 09h mask 02h counts writeback misses; expected zero.
// - Event 09h mask 04h counts io_hub or remote snoop misses.
// - Event 09h mask 03h counts all read and write misses.
// - Event 0Ah counts fills: 01h M, 02h E, 04h S, 08h F.
// - Modified fill counts only when forwarded for snoop RFO.
// - Event 0Ah mask 0Fh counts fills in any state; M fills only when forwarded for snoop RFO.
// - Event 0Bh counts victims: M, E, S, I, F by mask bit.
// - Modified victims are written home; each one is counted.
// - Event 0Bh mask 1Fh counts victims in any state.
// - Event 20h mask 01h io_hub reads, 02h io_hub writes.
// - Event 20h mask 04h remote reads, 08h remote writes.
// - Event 20h mask 10h counts local socket read requests.
// - Event 08h mask 01h counts code, data read and RFO hits.
// - Event 20h mask 20h counts local socket write requests.
`timescale 1ns/1ps
`default_nettype none
module uncore_cache_event_selector
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Raw occurrences from the shared cache and home logic
   input wire evsel_pkg::cache_access_t cache_acc,
   input wire evsel_pkg::line_move_t line_move,
   input wire evsel_pkg::home_req_t home_req,
   // Count enables to the counter array
   output logic [evsel_pkg::NUM_CTR-1:0] count_en
);
   localparam int N = evsel_pkg::NUM_CTR;

   logic [15:0] sel_reg [N];
   logic [31:0] cnt_reg [N];
   logic [N-1:0] match;
   logic [N-1:0] count_en_reg;
   logic [31:0] rdata_next;
   logic wr_acc;
   logic rd_acc;
   logic addr_ok;

   // Word index of a counter-relative offset
   function automatic logic [1:0] word_idx(input logic [11:0] a,
                                           input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      word_idx = d[3:2];
   endfunction

   // True when the address falls in a four-word bank
   function automatic logic in_bank(input logic [11:0] a,
                                    input logic [11:0] base);
      in_bank = (a[11:4] == base[11:4]) && (a[1:0] == 2'h0);
   endfunction

   // Zero-wait APB: every access completes in its first access cycle
   assign pready = 1'b1;
   assign addr_ok = in_bank(paddr, evsel_pkg::SEL_BASE) ||
                    in_bank(paddr, evsel_pkg::CNT_BASE) ||
                    (paddr == evsel_pkg::STAT_OFF);
   assign pslverr = psel && penable && !addr_ok;
   assign wr_acc = psel && penable && pwrite && addr_ok;
   assign rd_acc = psel && !penable && !pwrite;

   // Event selectors: event number low byte, unit mask high byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < N; i++)
            sel_reg[i] <= evsel_pkg::SEL_RESET;
      end
      else if (wr_acc && in_bank(paddr, evsel_pkg::SEL_BASE))
      begin
         if (pstrb[0])
            sel_reg[word_idx(paddr, evsel_pkg::SEL_BASE)][7:0] <= pwdata[7:0];
         if (pstrb[1])
            sel_reg[word_idx(paddr, evsel_pkg::SEL_BASE)][15:8] <=
               pwdata[15:8];
      end
   end

   // Qualifier per counter
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : gen_match
         event_match u_match
         (
            .ev_num(sel_reg[g][7:0]),
            .umask(sel_reg[g][15:8]),
            .acc(cache_acc),
            .mv(line_move),
            .req(home_req),
            .hit(match[g])
         );
      end
   endgenerate

   // One-cycle count enable per qualified occurrence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_en_reg <= '0;
      else
         count_en_reg <= match;
   end
   assign count_en = count_en_reg;

   // Local counters, cleared on reset, loaded with pwdata by software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < N; i++)
            cnt_reg[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (wr_acc && in_bank(paddr, evsel_pkg::CNT_BASE) &&
                word_idx(paddr, evsel_pkg::CNT_BASE) == 2'(i))
               cnt_reg[i] <= pwdata;
            else if (count_en_reg[i])
               cnt_reg[i] <= cnt_reg[i] + 32'h00000001;
         end
      end
   end

   // Read mux
   always_comb
   begin
      rdata_next = 32'h00000000;
      if (in_bank(paddr, evsel_pkg::SEL_BASE))
         rdata_next = {16'h0000, sel_reg[word_idx(paddr, evsel_pkg::SEL_BASE)]};
      else if (in_bank(paddr, evsel_pkg::CNT_BASE))
         rdata_next = cnt_reg[word_idx(paddr, evsel_pkg::CNT_BASE)];
      else if (paddr == evsel_pkg::STAT_OFF)
         rdata_next = {{(32-N){1'b0}}, count_en_reg};
   end

   // Read data captured in the setup cycle, valid in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_acc)
         prdata <= rdata_next;
   end

endmodule
`default_nettype wire

// ---- hdl/evsel_pkg.sv ----
package evsel_pkg;
   // Event numbers
   localparam logic [7:0] EV_HIT = 8'h08;
   localparam logic [7:0] EV_MISS = 8'h09;
   localparam logic [7:0] EV_FILL = 8'h0a;
   localparam logic [7:0] EV_VICTIM = 8'h0b;
   localparam logic [7:0] EV_HOME = 8'h20;

   // Hit and miss mask bits
   localparam int M_READ = 0;
   localparam int M_WRITE = 1;
   localparam int M_SNOOP = 2;

   // Coherence state mask bits (fill: M E S F; victim: M E S I F)
   localparam int M_MOD = 0;
   localparam int M_EXC = 1;
   localparam int M_SHR = 2;
   localparam int M_FILL_FWD = 3;
   localparam int M_INV = 3;
   localparam int M_VIC_FWD = 4;

   // Home request mask bits
   localparam int M_IO_RD = 0;
   localparam int M_IO_WR = 1;
   localparam int M_REM_RD = 2;
   localparam int M_REM_WR = 3;
   localparam int M_LOC_RD = 4;
   localparam int M_LOC_WR = 5;

   // Number of counters steered by the selector
   localparam int NUM_CTR = 4;

   // Register map (word offsets in bytes)
   localparam logic [11:0] SEL_BASE = 12'h000;
   localparam logic [11:0] CNT_BASE = 12'h010;
   localparam logic [11:0] STAT_OFF = 12'h020;
   localparam logic [15:0] SEL_RESET = 16'h0000;

   // Shared cache access report
   typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_SNOOP} acc_kind_t;
   typedef struct packed
   {
      logic valid;
      logic hit;
      acc_kind_t kind;
   } cache_access_t;

   // Line fill and victim report; state one-hot M E S I F
   typedef struct packed
   {
      logic fill_valid;
      logic [4:0] fill_state;
      logic fill_snoop_rfo;
      logic victim_valid;
      logic [4:0] victim_state;
   } line_move_t;

   localparam int ST_M = 0;
   localparam int ST_E = 1;
   localparam int ST_S = 2;
   localparam int ST_I = 3;
   localparam int ST_F = 4;

   // Home logic request report
   typedef enum logic [1:0] {SRC_IO, SRC_REMOTE, SRC_LOCAL} home_src_t;
   typedef struct packed
   {
      logic valid;
      home_src_t src;
      logic write;
   } home_req_t;
endpackage

// ---- hdl/event_match.sv ----
`timescale 1ns/1ps
`default_nettype none
// Qualifies one cycle of raw occurrences against one event selection
module event_match
(
   // Selection
   input wire logic [7:0] ev_num,
   input wire logic [7:0] umask,
   // Occurrences
   input wire evsel_pkg::cache_access_t acc,
   input wire evsel_pkg::line_move_t mv,
   input wire evsel_pkg::home_req_t req,
   // Result
   output logic hit
);
   logic [5:0] sub;

   // Sub-event vector for the chosen event; mask bits are ORed together
   always_comb
   begin
      sub = 6'h00;
      case (ev_num)
         evsel_pkg::EV_HIT, evsel_pkg::EV_MISS:
         begin
            if (acc.valid && (acc.hit == (ev_num == evsel_pkg::EV_HIT)))
            begin
               // Reads cover code, data and RFO
               sub[evsel_pkg::M_READ] =
                  (acc.kind == evsel_pkg::ACC_READ);
               // Writebacks always hit in the inclusive cache
               sub[evsel_pkg::M_WRITE] =
                  (acc.kind == evsel_pkg::ACC_WRITE);
               sub[evsel_pkg::M_SNOOP] =
                  (acc.kind == evsel_pkg::ACC_SNOOP);
            end
         end
         evsel_pkg::EV_FILL:
         begin
            if (mv.fill_valid)
            begin
               // Modified fill counts only when forwarded for a snoop RFO
               sub[evsel_pkg::M_MOD] = mv.fill_state[evsel_pkg::ST_M] &&
                                       mv.fill_snoop_rfo;
               sub[evsel_pkg::M_EXC] =
                  mv.fill_state[evsel_pkg::ST_E];
               sub[evsel_pkg::M_SHR] =
                  mv.fill_state[evsel_pkg::ST_S];
               sub[evsel_pkg::M_FILL_FWD] =
                  mv.fill_state[evsel_pkg::ST_F];
            end
         end
         evsel_pkg::EV_VICTIM:
         begin
            if (mv.victim_valid)
            begin
               // Each modified victim is written back home and counted
               sub[evsel_pkg::M_MOD] =
                  mv.victim_state[evsel_pkg::ST_M];
               sub[evsel_pkg::M_EXC] =
                  mv.victim_state[evsel_pkg::ST_E];
               sub[evsel_pkg::M_SHR] =
                  mv.victim_state[evsel_pkg::ST_S];
               sub[evsel_pkg::M_INV] =
                  mv.victim_state[evsel_pkg::ST_I];
               sub[evsel_pkg::M_VIC_FWD] =
                  mv.victim_state[evsel_pkg::ST_F];
            end
         end
         evsel_pkg::EV_HOME:
         begin
            if (req.valid)
            begin
               sub[evsel_pkg::M_IO_RD] = (req.src == evsel_pkg::SRC_IO) &&
                                         !req.write;
               sub[evsel_pkg::M_IO_WR] = (req.src == evsel_pkg::SRC_IO) &&
                                         req.write;
               sub[evsel_pkg::M_REM_RD] = (req.src == evsel_pkg::SRC_REMOTE) &&
                                          !req.write;
               sub[evsel_pkg::M_REM_WR] = (req.src == evsel_pkg::SRC_REMOTE) &&
                                          req.write;
               sub[evsel_pkg::M_LOC_RD] = (req.src == evsel_pkg::SRC_LOCAL) &&
                                          !req.write;
               sub[evsel_pkg::M_LOC_WR] = (req.src == evsel_pkg::SRC_LOCAL) &&
                                          req.write;
            end
         end
         default: sub = 6'h00;
      endcase
   end

   // One count per occurrence however many mask bits match
   assign hit = |(sub & umask[5:0]);

endmodule
`default_nettype wire

// ---- bench/evsel_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module evsel_asserts
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Occurrences and enables
   input wire evsel_pkg::cache_access_t cache_acc,
   input wire evsel_pkg::line_move_t line_move,
   input wire evsel_pkg::home_req_t home_req,
   input wire logic [evsel_pkg::NUM_CTR-1:0] count_en
);
   logic [15:0] sel0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of selector 0 so checks know what counter 0 follows
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sel0 <= 16'h0000;
      else if (psel && penable && pwrite && paddr == 12'h000)
         sel0 <= pwdata[15:0];
   // Occurrence patterns seen while counter 0 is selected
   sequence s_wb_hit;
      sel0 == 16'h0208 && cache_acc.valid && cache_acc.hit
         && cache_acc.kind == evsel_pkg::ACC_WRITE;
   endsequence
   sequence s_read_miss;
      sel0 == 16'h0109 && cache_acc.valid && !cache_acc.hit
         && cache_acc.kind == evsel_pkg::ACC_READ;
   endsequence
   sequence s_mod_fill;
      sel0 == 16'h010a && line_move.fill_valid
         && line_move.fill_state[evsel_pkg::ST_M];
   endsequence
   chk_wb_hit: assert property (s_wb_hit |=> count_en[0])
      else $error("writeback hit not counted");
   chk_read_miss: assert property (s_read_miss |=> count_en[0])
      else $error("read miss not counted");
   chk_fill_rfo: assert property
      (s_mod_fill ##0 line_move.fill_snoop_rfo |=> count_en[0])
      else $error("forwarded modified fill not counted");
   chk_fill_plain: assert property
      (s_mod_fill ##0 !line_move.fill_snoop_rfo |=> !count_en[0])
      else $error("modified fill counted without snoop");
   chk_victim_mod: assert property
      (sel0 == 16'h010b && line_move.victim_valid
         && line_move.victim_state[evsel_pkg::ST_M] |=> count_en[0])
      else $error("modified victim not counted");
   chk_victim_any: assert property
      (sel0 == 16'h1f0b && line_move.victim_valid |=> count_en[0])
      else $error("victim not counted");
   chk_io_read: assert property
      (sel0 == 16'h0120 && home_req.valid && !home_req.write
         && home_req.src == evsel_pkg::SRC_IO |=> count_en[0])
      else $error("io hub read not counted");
   chk_unknown_ev: assert property
      (sel0[7:0] == 8'h05 |=> !count_en[0])
      else $error("unknown event counted");
   chk_idle_quiet: assert property
      (!cache_acc.valid && !line_move.fill_valid && !line_move.victim_valid
         && !home_req.valid |=> count_en == '0)
      else $error("enable without occurrence");
endmodule
bind uncore_cache_event_selector evsel_asserts chk_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .cache_acc(cache_acc),
   .line_move(line_move), .home_req(home_req), .count_en(count_en));
`default_nettype wire

// ---- bench/occurrence_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: random cache, line and home occurrences, one-hot states
module occurrence_source
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic act,
   input wire logic [31:0] rnd,
   // Occurrences
   output var evsel_pkg::cache_access_t cache_acc,
   output var evsel_pkg::line_move_t line_move,
   output var evsel_pkg::home_req_t home_req
);
   // Unused fields carry noise, as the real logic would
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cache_acc <= '0;
         line_move <= '0;
         home_req <= '0;
      end
      else
      begin
         cache_acc <= '{act & rnd[0], rnd[1],
            evsel_pkg::acc_kind_t'(rnd[3:2] % 3)};
         line_move <= '{act & rnd[4],
            5'h01 << (rnd[6:5] == 2'h3 ? 4 : rnd[6:5]), rnd[7],
            act & rnd[8], 5'h01 << (rnd[11:9] % 5)};
         home_req <= '{act & rnd[12],
            evsel_pkg::home_src_t'(rnd[14:13] % 3), rnd[15]};
      end
endmodule
`default_nettype wire

// ---- bench/uncore_cache_event_selector_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module uncore_cache_event_selector_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, act = 0;
   logic pready, pslverr, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rnd = 32'h46, prdata, rd;
   logic [3:0] count_en, exp_q = '0;
   evsel_pkg::cache_access_t acc;
   evsel_pkg::line_move_t mv;
   evsel_pkg::home_req_t req;
   logic [15:0] sel [4] = '{default: '0};
   logic [15:0] tbl [28] = '{16'h0208, 16'h0408, 16'h0308, 16'h0108,
      16'h0109, 16'h0209, 16'h0409, 16'h0309, 16'h010a, 16'h020a, 16'h040a,
      16'h080a, 16'h010b, 16'h020b, 16'h040b, 16'h080b, 16'h0120, 16'h0220,
      16'h0420, 16'h0820, 16'h0005, 16'h0f0a, 16'h1020, 16'h100b, 16'h1f0b,
      16'h3f20, 16'h2020, 16'h0000};
   int cnt [4] = '{default: 0};
   int error_cnt = 0, tests_run = 0;
   // Clock
   initial forever #5 pclk = ~pclk;
   // Block and far side
   uncore_cache_event_selector dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cache_acc(acc), .line_move(mv), .home_req(req),
      .count_en(count_en));
   occurrence_source src_i (.pclk(pclk), .presetn(presetn), .act(act),
      .rnd(rnd), .cache_acc(acc), .line_move(mv), .home_req(req));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Reference match of one selection against this cycle's occurrences
   function automatic logic m(logic [15:0] s);
      case (s[7:0])
         8'h08: return acc.valid && acc.hit && s[8 + int'(acc.kind)];
         8'h09: return acc.valid && !acc.hit && s[8 + int'(acc.kind)];
         8'h0a: return mv.fill_valid && |(s[11:8] & {mv.fill_state[4],
            mv.fill_state[2:1], mv.fill_state[0] & mv.fill_snoop_rfo});
         8'h0b: return mv.victim_valid && |(s[12:8] & mv.victim_state);
         8'h20: return req.valid && s[8 + 2 * int'(req.src) + int'(req.write)];
         default: return 1'b0;
      endcase
   endfunction
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Expected enables and counts from the inputs before each edge
   always @(posedge pclk)
      for (int i = 0; i < 4; i++)
      begin
         exp_q[i] <= m(sel[i]);
         cnt[i] += m(sel[i]);
      end
   // Enables compared every cycle once settled
   always @(negedge pclk)
      if (presetn)
         check("count_en", {28'h0, count_en}, {28'h0, exp_q});
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int s = 0; s < 7; s++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            sel[i] = tbl[4 * s + i];
            // Upper lanes carry noise that the selector must drop
            apb(1'b1, 12'(4 * i), {16'hffff, sel[i]});
            apb(1'b1, 12'(16 + 4 * i), 32'h0);
            cnt[i] = 0;
         end
         act <= 1'b1;
         repeat (200) @(posedge pclk) rnd <= xs(rnd);
         act <= 1'b0;
         repeat (3) @(posedge pclk);
         for (int i = 0; i < 4; i++)
         begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("selector", rd, {16'h0000, sel[i]});
            apb(1'b0, 12'(16 + 4 * i), 32'h0);
            check("counter", rd, cnt[i]);
            check("mapped error", {31'h0, er}, 32'h0);
         end
      end
      // Status mirrors the enables, all quiet while idle
      apb(1'b0, 12'h020, 32'h0);
      check("status", rd, 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      check("unmapped error", {31'h0, er}, 32'h1);
      check("unmapped data", rd, 32'h0);
      summarize();
   end
   // Watchdog
   initial
   begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
